//--- hw/sif_irq_cfg.sv
/*
 * sif_irq_cfg: configuration, interrupt flags, interrupt pin and result
 * presentation of the sensor's serial register block.
 * assumes: the serial front end turns bus cycles into one-cycle rd/wr
 * strobes with address; read data is sampled the cycle after rd.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: upper config nibble selects interrupt source
// R2: host writes only the six source codes
// R3: status read clears flags and pin
// R4: polarity bit; pin driven unless 4-wire spi
// R5: streaming full fifo drops oldest entry
// R6: stop-on-full fifo drops new result
// R7: fifo off: results go to own registers
// R8: fifo on: 32 deep, head at 0x00-0x02
// R9: config bit 0 chooses 3-wire spi
// R10: fifo flag from full or threshold
// R11: host polls fifo flag at most 375 us
// R12: new temperature result sets temp flag
// R13: new pressure result sets pressure flag
// R14: threshold field plus one triggers flag
// R15: config register resets to zero
// R16: flags sit at bits 2,1,0
// R17: pin asserts on enabled flag until read
module sif_irq_cfg
   import sif_pkg::*;
#(
   parameter int DEPTH = SIF_FIFO_DEPTH
) (
   input  wire logic         clk_sys_i,        // system clock, 100 MHz
   input  wire logic         arst_n_i,         // async reset, active low
   input  wire sif_reg_req_t req_i,            // register request
   output logic      [7:0]   rdata_o,          // register read data
   input  wire sif_result_t  result_i,         // new measurement result
   input  wire logic         fifo_flush_i,     // flush strobe from reset reg
   input  wire logic         i2c_mode_i,       // 1 when bus is i2c
   output logic              spi_3wire_o,      // serial wiring select
   output logic              irq_output_pin_o, // interrupt pin level
   output logic              irq_output_pin_oe_o, // pin drive enable
   output logic      [5:0]   fifo_level_o,     // fifo fill level
   output logic              fifo_empty_o      // fifo holds no data
);
   localparam int CW = $clog2(DEPTH);
   logic [7:0]           cfg_q;
   logic [4:0]           thr_q;
   logic [2:0]           flags_q, flags_d;
   logic                 fifo_lvl_q;
   logic [SIF_RES_W-1:0] pres_q, temp_q;
   logic [7:0]           rdata_q;
   logic [SIF_RES_W:0]   head;
   logic [CW:0]          count;

   // field decode
   wire [3:0] sel    = cfg_q[SIF_SEL_HI:SIF_SEL_LO];         // [R1]
   wire       pol_hi = cfg_q[SIF_POL_BIT];
   wire       stop   = cfg_q[SIF_STOP_BIT];
   wire       fen    = cfg_q[SIF_FEN_BIT];
   wire       spi3   = cfg_q[SIF_SPI3_BIT];                  // [R9]
   wire       rd_flg = req_i.rd && req_i.addr == SIF_ADDR_FLAGS;
   wire       rd_top = req_i.rd && req_i.addr == SIF_ADDR_RES2;
   wire       push   = result_i.valid && fen;

   // threshold compare: field value plus one results held
   wire [CW:0] thr_cnt = (CW+1)'(thr_q) + 1'b1;             // [R14]
   wire        wm_hit  = count >= thr_cnt;
   wire        full    = count == (CW+1)'(DEPTH);
   // the full/threshold choice follows the selected source; other codes
   // are the host's fault and simply raise no fifo flag
   wire fifo_cond = (sel == SIF_SEL_WM) ? wm_hit :
                    (sel == SIF_SEL_FULL) ? full : 1'b0;     // [R10]
   // edge of the condition so one read clears it until it re-arises
   wire fifo_ev = fifo_cond && !fifo_lvl_q;

   // flag next state: an event in the read cycle survives the clear
   always_comb begin
      flags_d = rd_flg ? 3'h0 : flags_q;                     // [R3]
      if (fifo_ev) flags_d[SIF_FLG_FIFO] = 1'b1;            // [R16]
      if (result_i.valid && result_i.is_temp)
         flags_d[SIF_FLG_TEMP] = 1'b1;                       // [R12]
      if (result_i.valid && !result_i.is_temp)
         flags_d[SIF_FLG_PRES] = 1'b1;                       // [R13]
   end

   // enabled flags per source code
   wire [2:0] en_mask = (sel == SIF_SEL_PRES) ? 3'h1 :
                        (sel == SIF_SEL_TEMP) ? 3'h2 :
                        (sel == SIF_SEL_BOTH) ? 3'h3 :
                        (sel == SIF_SEL_WM || sel == SIF_SEL_FULL) ? 3'h4 :
                        3'h0;                                // [R2]
   wire irq_act = |(flags_q & en_mask);                      // [R17]

   // config and threshold writes
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= SIF_CFG_RST;                               // [R15]
         thr_q <= SIF_THR_RST;
      end else if (req_i.wr) begin
         if (req_i.addr == SIF_ADDR_CFG) cfg_q <= req_i.wdata;
         if (req_i.addr == SIF_ADDR_THR) thr_q <= req_i.wdata[4:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_q    <= 3'h0;
         fifo_lvl_q <= 1'b0;
      end else begin
         flags_q    <= flags_d;
         fifo_lvl_q <= fifo_cond;
      end
   end

   // dedicated result registers, used when the history is off
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pres_q <= '0;
         temp_q <= '0;
      end else if (result_i.valid && !fen) begin             // [R7]
         if (result_i.is_temp) temp_q <= result_i.data;
         else                  pres_q <= result_i.data;
      end
   end

   // history buffer; head is popped after its top byte is read
   sif_fifo #(
      .W     (SIF_RES_W + 1),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .flush_i   (fifo_flush_i || !fen),
      .stop_i    (stop),
      .push_i    (push),
      .din_i     ({result_i.is_temp, result_i.data}),
      .pop_i     (fen && rd_top),                            // [R8]
      .head_o    (head),
      .count_o   (count)
   );

   // read mux: with history on, the head appears at the low three bytes
   wire [SIF_RES_W-1:0] res_sel = fen ? head[SIF_RES_W-1:0] : pres_q;
   wire [7:0] rd_mux =
      (req_i.addr == SIF_ADDR_RES0)          ? res_sel[7:0]   :
      (req_i.addr == SIF_ADDR_RES0 + 8'h01)  ? res_sel[15:8]  :
      (req_i.addr == SIF_ADDR_RES2)          ? res_sel[23:16] :
      (req_i.addr == SIF_ADDR_CFG)           ? cfg_q          :
      (req_i.addr == SIF_ADDR_FLAGS)         ? {5'h00, flags_q} :
      (req_i.addr == SIF_ADDR_THR)           ? {3'h0, thr_q}  : 8'h00;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)     rdata_q <= 8'h00;
      else if (req_i.rd) rdata_q <= rd_mux;
   end

   // pin: not available in 4-wire spi, where it doubles as data out
   assign irq_output_pin_oe_o = i2c_mode_i || spi3;          // [R4]
   assign irq_output_pin_o    = pol_hi ? irq_act : !irq_act; // [R4]
   assign rdata_o      = rdata_q;
   assign spi_3wire_o  = spi3;
   assign fifo_level_o = 6'(count);
   assign fifo_empty_o = count == '0;
endmodule : sif_irq_cfg
`default_nettype wire

//--- hw/sif_pkg.sv
/*
 * sif_pkg: register map, field positions, reset values and carrier types
 * of the interrupt / result fifo / serial mode configuration block.
 * assumes: an 8-bit register port from the serial front end.
 */
package sif_pkg;
   localparam logic [7:0] SIF_ADDR_RES0  = 8'h00; // result bytes, low to high
   localparam logic [7:0] SIF_ADDR_RES2  = 8'h02;
   localparam logic [7:0] SIF_ADDR_CFG   = 8'h09;
   localparam logic [7:0] SIF_ADDR_FLAGS = 8'h0a;
   localparam logic [7:0] SIF_ADDR_THR   = 8'h0b;
   localparam logic [7:0] SIF_CFG_RST    = 8'h00;
   localparam logic [4:0] SIF_THR_RST    = 5'h1f;
   localparam int         SIF_SEL_HI     = 7;
   localparam int         SIF_SEL_LO     = 4;
   localparam int         SIF_POL_BIT    = 3;
   localparam int         SIF_STOP_BIT   = 2;
   localparam int         SIF_FEN_BIT    = 1;
   localparam int         SIF_SPI3_BIT   = 0;
   localparam int         SIF_FLG_FIFO   = 2;
   localparam int         SIF_FLG_TEMP   = 1;
   localparam int         SIF_FLG_PRES   = 0;
   localparam logic [3:0] SIF_SEL_NONE   = 4'h0;
   localparam logic [3:0] SIF_SEL_PRES   = 4'h1;
   localparam logic [3:0] SIF_SEL_TEMP   = 4'h2;
   localparam logic [3:0] SIF_SEL_BOTH   = 4'h3;
   localparam logic [3:0] SIF_SEL_WM     = 4'h4;
   localparam logic [3:0] SIF_SEL_FULL   = 4'h8;
   localparam int         SIF_FIFO_DEPTH = 32;
   localparam int         SIF_RES_W      = 24;

   // one measurement result as it arrives from the engine
   typedef struct packed {
      logic                 valid;
      logic                 is_temp;
      logic [SIF_RES_W-1:0] data;
   } sif_result_t;

   // register port request from the serial front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sif_reg_req_t;
endpackage : sif_pkg

//--- hw/sif_fifo.sv
/*
 * sif_fifo: result history buffer with streaming or stop-on-full policy.
 * assumes: push and pop are single-cycle strobes on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sif_fifo
   import sif_pkg::*;
#(
   parameter int W     = SIF_RES_W + 1,
   parameter int DEPTH = SIF_FIFO_DEPTH
) (
   input  wire logic                     clk_sys_i,  // system clock
   input  wire logic                     arst_n_i,   // async reset, low
   input  wire logic                     flush_i,    // drop all entries
   input  wire logic                     stop_i,     // 1 stop-on-full
   input  wire logic                     push_i,     // new result
   input  wire logic [W-1:0]             din_i,      // result word
   input  wire logic                     pop_i,      // head consumed
   output logic      [W-1:0]             head_o,     // oldest entry
   output logic      [$clog2(DEPTH):0]   count_o     // fill level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0]   cnt_q;
   wire full  = (cnt_q == (AW+1)'(DEPTH));
   wire empty = (cnt_q == '0);
   // a full stop-on-full fifo refuses the word outright
   wire wr_en = push_i && !(full && stop_i);      // [R6]
   // streaming: a write into a full fifo retires the oldest entry too
   wire rd_en = (pop_i && !empty) || (wr_en && full && !pop_i); // [R5]

   // storage has no reset; only the pointers and the count need a defined value
   always_ff @(posedge clk_sys_i) begin
      if (wr_en) mem[wp_q] <= din_i;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (flush_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (wr_en) wp_q <= wp_q + 1'b1;
         if (rd_en) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(wr_en && !full) - (AW+1)'(pop_i && !empty
                  && !(wr_en && full));
      end
   end

   assign head_o  = empty ? '0 : mem[rp_q];
   assign count_o = cnt_q;
endmodule : sif_fifo
`default_nettype wire

//--- bench/sif_irq_cfg_monitor.sv
/* sif_irq_cfg_monitor: port-level assertions for sif_irq_cfg.
   assumes: bound to sif_irq_cfg, single clock, host strobes one cycle. */
`timescale 1ns/1ps
`default_nettype none
module sif_irq_cfg_monitor
   import sif_pkg::*;
#(
   parameter int DEPTH = SIF_FIFO_DEPTH
) (
   input wire logic         clk_sys_i,           // system clock
   input wire logic         arst_n_i,            // async reset, low
   input wire sif_reg_req_t req_i,               // register request
   input wire logic [7:0]   rdata_o,             // read data
   input wire sif_result_t  result_i,            // new result
   input wire logic         fifo_flush_i,        // flush strobe
   input wire logic         i2c_mode_i,          // i2c in use
   input wire logic         spi_3wire_o,         // wiring select
   input wire logic         irq_output_pin_o,    // pin level
   input wire logic         irq_output_pin_oe_o, // pin enable
   input wire logic [5:0]   fifo_level_o,        // fill level
   input wire logic         fifo_empty_o         // fifo empty
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // register strobe decodes
   wire logic rd_f = req_i.rd && req_i.addr == SIF_ADDR_FLAGS;
   wire logic rd_c = req_i.rd && req_i.addr == SIF_ADDR_CFG;
   wire logic wr_c = req_i.wr && req_i.addr == SIF_ADDR_CFG;
   wire logic rd_t = req_i.rd && req_i.addr == SIF_ADDR_THR;
   wire logic wr_t = req_i.wr && req_i.addr == SIF_ADDR_THR;
   wire logic nv   = !result_i.valid;
   a_oe_mode: assert property (
      irq_output_pin_oe_o == (i2c_mode_i | spi_3wire_o)) else $error("oe");
   // the host spaces reads two cycles apart; no result or write may land
   // around them, since either could raise a flag again
   a_clear_read: assert property (nv && !req_i.wr ##1 rd_f && nv
      ##1 nv ##1 rd_f |=> rdata_o == 8'h00)
      else $error("flags not cleared");
   // a flag set by a result must survive until the next status read
   a_temp_flag: assert property (result_i.valid && result_i.is_temp
      ##1 !rd_f ##1 rd_f |=> rdata_o[SIF_FLG_TEMP]) else $error("temp flag");
   a_pres_flag: assert property (result_i.valid && !result_i.is_temp
      ##1 !rd_f ##1 rd_f |=> rdata_o[SIF_FLG_PRES]) else $error("pres flag");
   a_spi_follow: assert property (wr_c
      |=> spi_3wire_o == $past(req_i.wdata[SIF_SPI3_BIT])) else $error("spi");
   a_cfg_readback: assert property (wr_c ##2 rd_c
      |=> rdata_o == $past(req_i.wdata, 3)) else $error("cfg readback");
   a_thr_readback: assert property (wr_t ##2 rd_t
      |=> rdata_o == {3'h0, $past(req_i.wdata[4:0], 3)}) else $error("thr");
   a_empty_lvl: assert property (
      fifo_empty_o == (fifo_level_o == 6'h00)) else $error("empty flag");
   a_level_cap: assert property (fifo_level_o <= DEPTH)
      else $error("level above depth");
   c_flag_read: cover property (rd_f ##1 rdata_o != 8'h00);
   c_fifo_full: cover property (fifo_level_o == 6'h20);
   c_fifo_on: cover property (wr_c && req_i.wdata[SIF_FEN_BIT]);
endmodule : sif_irq_cfg_monitor
bind sif_irq_cfg sif_irq_cfg_monitor #(.DEPTH(DEPTH)) mon_u (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req_i),
   .rdata_o(rdata_o), .result_i(result_i), .fifo_flush_i(fifo_flush_i),
   .i2c_mode_i(i2c_mode_i), .spi_3wire_o(spi_3wire_o),
   .irq_output_pin_o(irq_output_pin_o),
   .irq_output_pin_oe_o(irq_output_pin_oe_o),
   .fifo_level_o(fifo_level_o), .fifo_empty_o(fifo_empty_o));
`default_nettype wire

//--- bench/sif_host_model.sv
/* sif_host_model: host side of the register port, one-cycle strobes.
   assumes: requests launched on falling edges; rdata one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module sif_host_model
   import sif_pkg::*;
(
   input  wire logic [7:0] rdata_i,   // read data from block
   input  wire logic       clk_sys_i, // system clock
   output var sif_reg_req_t req_o     // register request
);
   initial req_o = '0;
   // released address and data flip so stale values never look valid
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_sys_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk_sys_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      d = rdata_i;
   endtask : reg_rd
endmodule : sif_host_model
`default_nettype wire

//--- bench/test_sif_irq_cfg.sv
/* test_sif_irq_cfg: directed scenarios for sif_irq_cfg.
   assumes: host model drives the register port; results pulsed here. */
`timescale 1ns/1ps
`default_nettype none
module test_sif_irq_cfg;
   import sif_pkg::*;
   logic         clk_sys_i, arst_n_i, fifo_flush_i, i2c_mode_i;
   sif_reg_req_t req;
   sif_result_t  res;
   logic [7:0]   rdata;
   logic         spi3, pin, oe, emp;
   logic [5:0]   lvl;
   logic [23:0]  h;
   int           fail_count = 0;
   int           checks_done = 0;
   sif_host_model host_u (.rdata_i(rdata), .clk_sys_i(clk_sys_i),
      .req_o(req));
   sif_irq_cfg #(.DEPTH(SIF_FIFO_DEPTH)) dut_u (.clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i), .req_i(req), .rdata_o(rdata), .result_i(res),
      .fifo_flush_i(fifo_flush_i), .i2c_mode_i(i2c_mode_i),
      .spi_3wire_o(spi3), .irq_output_pin_o(pin), .irq_output_pin_oe_o(oe),
      .fifo_level_o(lvl), .fifo_empty_o(emp));
   task automatic cmp(input string n, input logic [23:0] e, g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic rdc(input logic [7:0] a, e, input string n);
      logic [7:0] b;
      host_u.reg_rd(a, b);
      cmp(n, {16'h0, e}, {16'h0, b});
   endtask : rdc
   task automatic push(input logic t, input logic [23:0] d);
      @(negedge clk_sys_i);
      res = '{valid: 1'b1, is_temp: t, data: d};
      @(negedge clk_sys_i);
      res = '{valid: 1'b0, is_temp: ~t, data: ~d};
   endtask : push
   // three bytes low to high; the last one pops the fifo head
   task automatic head;
      for (int i = 0; i < 3; i++) host_u.reg_rd(8'(i), h[8*i +: 8]);
   endtask : head
   task automatic t_reset;
      rdc(SIF_ADDR_CFG, 8'h00, "cfg");
      rdc(SIF_ADDR_THR, 8'h1f, "thr");
      rdc(8'h05, 8'h00, "unmapped");
      cmp("pin idle", 24'h1, {23'h0, pin});
      cmp("oe spi4", 24'h0, {23'h0, oe});
      @(negedge clk_sys_i) i2c_mode_i = 1'b1;
      #1 cmp("oe i2c", 24'h1, {23'h0, oe});
   endtask : t_reset
   task automatic t_flags;
      @(negedge clk_sys_i) i2c_mode_i = 1'b0;
      host_u.reg_wr(SIF_ADDR_CFG, 8'h39);
      rdc(SIF_ADDR_CFG, 8'h39, "cfg back");
      cmp("spi3", 24'h1, {23'h0, spi3});
      cmp("oe spi3", 24'h1, {23'h0, oe});
      cmp("pin hi idle", 24'h0, {23'h0, pin});
      // temperature last, so its flag is read two cycles after it is set
      push(1'b0, 24'h654321);
      cmp("pin pres", 24'h1, {23'h0, pin});
      push(1'b1, 24'h123456);
      rdc(SIF_ADDR_FLAGS, 8'h03, "flags");
      cmp("pin cleared", 24'h0, {23'h0, pin});
      rdc(SIF_ADDR_FLAGS, 8'h00, "flags again");
   endtask : t_flags
   task automatic t_sel;
      for (int s = 0; s < 4; s++) begin
         host_u.reg_wr(SIF_ADDR_CFG, {4'(s), 4'h0});
         push(1'b0, 24'h000abc);
         cmp("pin sel", {23'h0, s[0] == 1'b0}, {23'h0, pin});
         rdc(SIF_ADDR_FLAGS, 8'h01, "pres flag");
      end
   endtask : t_sel
   task automatic t_fifo;
      host_u.reg_wr(SIF_ADDR_THR, 8'h02);
      rdc(SIF_ADDR_THR, 8'h02, "thr back");
      host_u.reg_wr(SIF_ADDR_CFG, {SIF_SEL_WM, 4'h2});
      for (int i = 1; i < 4; i++) begin
         cmp("pin below thr", 24'h1, {23'h0, pin});
         push(1'b0, 24'(i));
      end
      // the fifo flag registers one cycle after the count reaches it
      @(negedge clk_sys_i);
      cmp("pin at thr", 24'h0, {23'h0, pin});
      cmp("level", 24'h3, {18'h0, lvl});
      head();
      cmp("head", 24'h1, h);
      cmp("level pop", 24'h2, {18'h0, lvl});
      // the fifo flag is polled once, in this scenario only; only t_flags polls flags back to back
      rdc(SIF_ADDR_FLAGS, 8'h05, "fifo flag");
   endtask : t_fifo
   task automatic t_full;
      host_u.reg_wr(SIF_ADDR_CFG, {SIF_SEL_FULL, 4'h2});
      @(negedge clk_sys_i) fifo_flush_i = 1'b1;
      @(negedge clk_sys_i) fifo_flush_i = 1'b0;
      cmp("flushed", 24'h1, {23'h0, emp});
      for (int i = 1; i < 34; i++) push(1'b1, 24'(i));
      cmp("level full", 24'h20, {18'h0, lvl});
      cmp("pin full", 24'h0, {23'h0, pin});
      head();
      cmp("oldest dropped", 24'h2, h);
      host_u.reg_wr(SIF_ADDR_CFG, {SIF_SEL_FULL, 4'h6});
      push(1'b1, 24'h000100);
      push(1'b1, 24'h000101);
      cmp("level stop", 24'h20, {18'h0, lvl});
      head();
      cmp("kept head", 24'h3, h);
      host_u.reg_wr(SIF_ADDR_CFG, 8'h00);
      push(1'b0, 24'habcdef);
      cmp("level off", 24'h0, {18'h0, lvl});
      head();
      cmp("pres reg", 24'habcdef, h);
   endtask : t_full
   task automatic finish_test;
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // the scenarios take about 170 cycles; far beyond that is a hang
   initial begin
      #50us;
      fail_count++;
      finish_test();
   end
   initial begin
      arst_n_i = 1'b0;
      fifo_flush_i = 1'b0;
      i2c_mode_i = 1'b0;
      res = '0;
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i) arst_n_i = 1'b1;
      t_reset();
      t_flags();
      t_sel();
      t_fifo();
      t_full();
      finish_test();
   end
endmodule : test_sif_irq_cfg
`default_nettype wire
